/* File: pkg/tpc_pkg.sv */
/*
  Constants and types for the timer pair, capture and compare block.
  Assumes a 32-bit APB register bus with byte addresses and 16-bit
  registers in the low half of each word.
*/
package tpc_pkg;

  // Register byte offsets
  localparam int unsigned APB_AW       = 8;
  localparam logic [7:0]  OFS_TCTL0    = 8'h00;
  localparam logic [7:0]  OFS_TCTL1    = 8'h04;
  localparam logic [7:0]  OFS_CNT0     = 8'h08;
  localparam logic [7:0]  OFS_CNT1     = 8'h0C;
  localparam logic [7:0]  OFS_PER0     = 8'h10;
  localparam logic [7:0]  OFS_PER1     = 8'h14;
  localparam logic [7:0]  OFS_CAPCTL   = 8'h18;
  localparam logic [7:0]  OFS_CAPBUF   = 8'h1C;
  localparam logic [7:0]  OFS_CMPCTL   = 8'h20;
  localparam logic [7:0]  OFS_CMPVAL0  = 8'h24;
  localparam logic [7:0]  OFS_CMPVAL1  = 8'h28;
  localparam logic [7:0]  OFS_STATUS   = 8'h2C;

  // Timer control fields
  localparam int unsigned T_RUN        = 15;
  localparam int unsigned T_IDLE       = 13;
  localparam int unsigned T_GATE       = 6;
  localparam int unsigned T_PS_HI      = 5;
  localparam int unsigned T_PS_LO      = 4;
  localparam int unsigned T_CHAIN      = 3;
  localparam int unsigned T_CKSRC      = 1;
  localparam logic [15:0] TCTL0_MASK   = 16'hA07A;
  localparam logic [15:0] TCTL1_MASK   = 16'hA072;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0]  PS_TERM_1    = 8'h00;
  localparam logic [7:0]  PS_TERM_8    = 8'h07;
  localparam logic [7:0]  PS_TERM_64   = 8'h3F;
  localparam logic [7:0]  PS_TERM_256  = 8'hFF;

  // Capture control fields
  localparam int unsigned C_IDLE       = 13;
  localparam int unsigned C_TSEL       = 7;
  localparam int unsigned C_CPI_HI     = 6;
  localparam int unsigned C_CPI_LO     = 5;
  localparam int unsigned C_OV         = 4;
  localparam int unsigned C_BNE        = 3;
  localparam int unsigned C_MODE_HI    = 2;
  localparam logic [15:0] CAPCTL_MASK  = 16'h20E7;
  localparam logic [3:0]  EDGE_TERM4   = 4'h3;
  localparam logic [3:0]  EDGE_TERM16  = 4'hF;

  typedef enum logic [2:0] {
    CAP_OFF    = 3'b000,
    CAP_BOTH   = 3'b001,
    CAP_FALL   = 3'b010,
    CAP_RISE   = 3'b011,
    CAP_RISE4  = 3'b100,
    CAP_RISE16 = 3'b101,
    CAP_UNUSED = 3'b110,
    CAP_WAKE   = 3'b111
  } tpc_cap_mode_type;

  // Compare control fields
  localparam int unsigned K_MODE_HI    = 2;
  localparam int unsigned K_TSEL       = 3;
  localparam int unsigned K_IRQEN      = 4;
  localparam logic [2:0]  CMP_SINGLE   = 3'b100;

  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_RISE = 2'b01,
    OC_FALL = 2'b10,
    OC_DONE = 2'b11
  } tpc_oc_state_type;

  // Status flag positions
  localparam int unsigned S_TMR0       = 0;
  localparam int unsigned S_TMR1       = 1;
  localparam int unsigned S_CAP        = 2;
  localparam int unsigned S_WAKE       = 3;
  localparam int unsigned S_CMP        = 4;
  localparam int unsigned S_W          = 5;

endpackage

/* File: src/tpc_top.sv */
/*
  Timer pair with 32-bit chaining, one input capture channel with a
  small capture buffer, and one single-pulse output compare channel,
  all behind an APB slave.
  Assumes pclk is the instruction clock, idle and sleep levels come
  from logic on pclk, and pins are asynchronous to pclk.
*/
// Function
// - Run bit starts or stops primary timer, or the chained pair.
// - Idle-stop bit halts its timer while the device idles.
// - Gate bit counts only while gate high, internal clock only.
// - Prescale field divides by 1, 8, 64 or 256.
// - Chain bit joins both timers into one 32-bit timer.
// - Secondary control bits are ignored while chained.
// - Clock source picks external pin rising edges or internal clock.
// - Secondary count holds the upper word when chained.
// - Chained period match sets the secondary timer flag.
// - Count equal to period returns to zero and keeps counting.
// - Capture idle-stop bit halts capture while the device idles.
// - Capture timer select stores primary count when set.
// - Capture flag raised after one to four captures.
// - Read-only overflow flag, cleared only by hardware.
// - Read-only buffer-not-empty flag while captures remain.
// - Capture modes for falling, rising, every 4th, every 16th rise.
// - Both-edge mode ignores captures-per-interrupt field.
// - Mode 111 is a rising-edge wake source in sleep or idle only.
// - Modes 000 and 110 leave the capture channel off.
// - Writing compare mode 100 drives pin low and arms one pulse.
// - First primary compare match drives the pin high.
// - Secondary compare match drives pin low, then stays low.
// - Second match sets compare flag; request only when enabled.
// - Rewriting mode 100 rearms without touching the timer.
`timescale 1ns/1ns
module tpc_top #(
  parameter int unsigned CAP_DEPTH = 4
) (
  input  wire logic                       pclk,          // Clock
  input  wire logic                       presetn,       // Reset, low
  input  wire logic                       ce,            // Clock enable
  input  wire logic                       psel,          // APB select
  input  wire logic                       penable,       // APB enable
  input  wire logic                       pwrite,        // APB write
  input  wire logic [tpc_pkg::APB_AW-1:0] paddr,         // APB address
  input  wire logic [31:0]                pwdata,        // APB wdata
  output logic      [31:0]                prdata,        // APB rdata
  output logic                            pready,        // APB ready
  output logic                            pslverr,       // APB error
  input  wire logic                       idle_mode,     // Device idle
  input  wire logic                       sleep_mode,    // Device sleep
  input  wire logic [1:0]                 ext_timer_clock_pin, // Pins
  input  wire logic [1:0]                 gate_pin,      // Gate pins
  input  wire logic                       capture_pin,   // Capture pin
  output logic                            compare_out_pin,   // Pulse
  output logic                            primary_timer_irq_flag, // Period
  output logic                            secondary_timer_irq_flag, // Chain
  output logic                            capture_irq_flag,  // Capture
  output logic                            capture_wake_flag, // Wake
  output logic                            compare_irq_flag,  // Compare
  output logic                            compare_irq_req    // Masked
);
  import tpc_pkg::*;

  localparam int unsigned PW = $clog2(CAP_DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (CAP_DEPTH < 2 || CAP_DEPTH > 16 || (1 << PW) != CAP_DEPTH) begin
    $error("CAP_DEPTH must be a power of two from 2 to 16");
  end
  logic [1:0][15:0]   tctl_reg;
  logic [1:0][15:0]   cnt_reg;
  logic [1:0][15:0]   cnt_next;
  logic [1:0][15:0]   per_reg;
  logic [15:0]        capctl_reg;
  logic [4:0]         cmpctl_reg;
  logic [1:0][15:0]   cmpval_reg;
  logic [S_W-1:0]     stat_reg;
  logic [S_W-1:0]     stat_set;
  logic [4:0]         sync1_reg;
  logic [4:0]         sync2_reg;
  logic [4:0]         sync3_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  logic               pin_reg;
  logic               irq_req_reg;
  logic [1:0]         tmr_hit;
  wire  [1:0]         tick;
  tpc_oc_state_type   oc_state_reg;
  tpc_oc_state_type   oc_state_next;
  logic [15:0]        fifo_mem [CAP_DEPTH];
  logic [PW-1:0]      wr_ptr_reg;
  logic [PW-1:0]      rd_ptr_reg;
  logic [PW:0]        fill_reg;
  logic               ov_reg;
  logic [3:0]         edge_cnt_reg;
  logic [1:0]         irq_cnt_reg;

  // APB decode; the answer comes one cycle into the access phase
  wire        access   = psel & penable;
  wire        wr_fire  = access & pwrite & pready_reg;
  wire        rd_fire  = access & ~pwrite & pready_reg;
  wire        sel_t0   = paddr == OFS_TCTL0;
  wire        sel_t1   = paddr == OFS_TCTL1;
  wire        sel_c0   = paddr == OFS_CNT0;
  wire        sel_c1   = paddr == OFS_CNT1;
  wire        sel_p0   = paddr == OFS_PER0;
  wire        sel_p1   = paddr == OFS_PER1;
  wire        sel_cap  = paddr == OFS_CAPCTL;
  wire        sel_buf  = paddr == OFS_CAPBUF;
  wire        sel_cmp  = paddr == OFS_CMPCTL;
  wire        sel_v0   = paddr == OFS_CMPVAL0;
  wire        sel_v1   = paddr == OFS_CMPVAL1;
  wire        sel_st   = paddr == OFS_STATUS;
  wire        hit      = sel_t0 | sel_t1 | sel_c0 | sel_c1 | sel_p0 |
                         sel_p1 | sel_cap | sel_buf | sel_cmp | sel_v0 |
                         sel_v1 | sel_st;
  wire [15:0] wd       = pwdata[15:0];

  // Capture status bits read back live beside the writable fields
  wire        buf_ne   = fill_reg != '0;
  wire [15:0] cap_rd   = (capctl_reg & CAPCTL_MASK) |
                         (16'(ov_reg) << C_OV) |
                         (16'(buf_ne) << C_BNE);
  wire [15:0] rd_word  =
      sel_t0  ? tctl_reg[0] :
      sel_t1  ? tctl_reg[1] :
      sel_c0  ? cnt_reg[0] :
      sel_c1  ? cnt_reg[1] :
      sel_p0  ? per_reg[0] :
      sel_p1  ? per_reg[1] :
      sel_cap ? cap_rd :
      sel_buf ? (buf_ne ? fifo_mem[rd_ptr_reg] : REG_RESET) :
      sel_cmp ? {11'h000, cmpctl_reg} :
      sel_v0  ? cmpval_reg[0] :
      sel_v1  ? cmpval_reg[1] :
      sel_st  ? {11'h000, stat_reg} : REG_RESET;

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg  <= access & ~pready_reg;
      if (access & ~pready_reg) begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
        pslverr_reg <= ~hit;
      end
    end
  end

  // Two-flop synchronisers, third flop only for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
    end else if (ce) begin
      sync1_reg <= {capture_pin, gate_pin, ext_timer_clock_pin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  wire chain = tctl_reg[0][T_CHAIN];
  // Per-timer clock selection, gating and prescaler
  for (genvar g = 0; g < 2; g++) begin : g_tmr
    logic [7:0] ps_reg;
    wire [15:0] ctl   = chain ? tctl_reg[0] : tctl_reg[g];
    wire        run   = ctl[T_RUN] & ~(idle_mode & ctl[T_IDLE]);
    wire        erise = sync2_reg[g] & ~sync3_reg[g];
    wire        src   = ctl[T_CKSRC] ? erise :
                        (~ctl[T_GATE] | sync2_reg[2+g]);
    wire [1:0]  psel2 = ctl[T_PS_HI:T_PS_LO];
    wire [7:0]  term  = (psel2 == 2'b11) ? PS_TERM_256 :
                        (psel2 == 2'b10) ? PS_TERM_64 :
                        (psel2 == 2'b01) ? PS_TERM_8 : PS_TERM_1;
    wire        wrap  = ps_reg >= term;
    assign tick[g] = run & src & wrap;
    // Prescaler restarts whenever its timer stops
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ps_reg <= 8'h00;
      end else if (ce) begin
        if (!run) begin
          ps_reg <= 8'h00;
        end else if (src) begin
          ps_reg <= wrap ? 8'h00 : ps_reg + 8'h01;
        end
      end
    end
  end

  // Count update; a bus write to a count wins over counting
  always_comb begin
    cnt_next = cnt_reg;
    tmr_hit  = 2'b00;
    if (chain) begin
      if (tick[0]) begin
        if (cnt_reg == per_reg) begin
          cnt_next   = 32'h0000_0000;
          tmr_hit[1] = 1'b1;
        end else begin
          cnt_next = cnt_reg + 32'h0000_0001;
        end
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tick[i]) begin
          if (cnt_reg[i] == per_reg[i]) begin
            cnt_next[i] = 16'h0000;
            tmr_hit[i]  = 1'b1;
          end else begin
            cnt_next[i] = cnt_reg[i] + 16'h0001;
          end
        end
      end
    end
    if (wr_fire && sel_c0) cnt_next[0] = wd;
    if (wr_fire && sel_c1) cnt_next[1] = wd;
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctl_reg   <= '0;
      per_reg    <= '0;
      capctl_reg <= REG_RESET;
      cmpval_reg <= '0;
      cmpctl_reg <= 5'h00;
      cnt_reg    <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      if (wr_fire) begin
        if (sel_t0)  tctl_reg[0]   <= wd & TCTL0_MASK;
        if (sel_t1)  tctl_reg[1]   <= wd & TCTL1_MASK;
        if (sel_p0)  per_reg[0]    <= wd;
        if (sel_p1)  per_reg[1]    <= wd;
        if (sel_cap) capctl_reg    <= wd & CAPCTL_MASK;
        if (sel_v0)  cmpval_reg[0] <= wd;
        if (sel_v1)  cmpval_reg[1] <= wd;
        if (sel_cmp) cmpctl_reg    <= wd[4:0];
      end
    end
  end

  // Capture edge qualification
  tpc_cap_mode_type cap_mode;
  assign cap_mode = tpc_cap_mode_type'(capctl_reg[C_MODE_HI:0]);
  wire cap_on   = ~(idle_mode & capctl_reg[C_IDLE]) &
                  (cap_mode != CAP_OFF) & (cap_mode != CAP_UNUSED)
                  & (cap_mode != CAP_WAKE);
  wire c_rise   = sync2_reg[4] & ~sync3_reg[4];
  wire c_fall   = ~sync2_reg[4] & sync3_reg[4];
  wire edge_ev  = (cap_mode == CAP_BOTH) ? (c_rise | c_fall) :
                  (cap_mode == CAP_FALL) ? c_fall : c_rise;
  wire prediv   = (cap_mode == CAP_RISE4) | (cap_mode == CAP_RISE16);
  wire [3:0] e_term = (cap_mode == CAP_RISE16) ? EDGE_TERM16 : EDGE_TERM4;
  wire cap_ev   = cap_on & edge_ev &
                  (~prediv | (edge_cnt_reg == e_term));
  wire full     = fill_reg == (PW+1)'(CAP_DEPTH);
  wire push     = cap_ev & ~full;
  wire pop      = rd_fire & sel_buf & buf_ne;
  wire [15:0] cap_val = capctl_reg[C_TSEL] ? cnt_reg[0] : cnt_reg[1];
  wire [1:0]  cpi     = capctl_reg[C_CPI_HI:C_CPI_LO];
  wire cap_irq  = cap_ev & ((cap_mode == CAP_BOTH) | (irq_cnt_reg == cpi));
  wire wake_ev  = (cap_mode == CAP_WAKE) & c_rise &
                  (sleep_mode | idle_mode);

  // Capture buffer; writing mode 000 flushes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      fill_reg     <= '0;
      ov_reg       <= 1'b0;
      edge_cnt_reg <= 4'h0;
      irq_cnt_reg  <= 2'b00;
    end else if (ce) begin
      if (cap_mode == CAP_OFF) begin
        wr_ptr_reg   <= '0;
        rd_ptr_reg   <= '0;
        fill_reg     <= '0;
        ov_reg       <= 1'b0;
        edge_cnt_reg <= 4'h0;
        irq_cnt_reg  <= 2'b00;
      end else begin
        if (push) begin
          fifo_mem[wr_ptr_reg] <= cap_val;
          wr_ptr_reg           <= wr_ptr_reg + PW'(1);
        end
        if (pop) rd_ptr_reg <= rd_ptr_reg + PW'(1);
        fill_reg <= fill_reg + (PW+1)'(push) - (PW+1)'(pop);
        if (cap_ev && full) ov_reg <= 1'b1;
        if (cap_on && prediv && c_rise) begin
          edge_cnt_reg <= (edge_cnt_reg == e_term) ? 4'h0
                                                   : edge_cnt_reg + 4'h1;
        end
        if (cap_ev) irq_cnt_reg <= cap_irq ? 2'b00 : irq_cnt_reg + 2'b01;
      end
    end
  end

  // Single-pulse compare; a write with mode 100 rearms it
  wire        arm     = wr_fire & sel_cmp &
                        (wd[K_MODE_HI:0] == CMP_SINGLE);
  wire        disarm  = wr_fire & sel_cmp & ~arm;
  wire [15:0] tbase   = cmpctl_reg[K_TSEL] ? cnt_reg[1] : cnt_reg[0];
  wire        m_pri   = tbase == cmpval_reg[0];
  wire        m_sec   = tbase == cmpval_reg[1];
  logic       cmp_done;
  always_comb begin
    oc_state_next = oc_state_reg;
    cmp_done      = 1'b0;
    unique case (oc_state_reg)
      OC_IDLE: oc_state_next = OC_IDLE;
      OC_RISE: if (m_pri) oc_state_next = OC_FALL;
      OC_FALL: if (m_sec) begin
        oc_state_next = OC_DONE;
        cmp_done      = 1'b1;
      end
      OC_DONE: oc_state_next = OC_DONE;
    endcase
    if (arm || disarm) begin
      oc_state_next = arm ? OC_RISE : OC_IDLE;
      cmp_done      = 1'b0;
    end
  end

  // Pin is high only while waiting for the trailing match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_state_reg <= OC_IDLE;
      pin_reg      <= 1'b0;
    end else if (ce) begin
      oc_state_reg <= oc_state_next;
      pin_reg      <= oc_state_next == OC_FALL;
    end
  end

  // Sticky flags, write one to clear; a new event beats the clear
  assign stat_set = {cmp_done, wake_ev, cap_irq, tmr_hit};
  wire [S_W-1:0] stat_clr = (wr_fire & sel_st) ? pwdata[S_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg    <= '0;
      irq_req_reg <= 1'b0;
    end else if (ce) begin
      stat_reg    <= (stat_reg & ~stat_clr) | stat_set;
      irq_req_reg <= stat_reg[S_CMP] & cmpctl_reg[K_IRQEN];
    end
  end

  assign prdata                   = prdata_reg;
  assign pready                   = pready_reg;
  assign pslverr                  = pslverr_reg;
  assign compare_out_pin          = pin_reg;
  assign primary_timer_irq_flag   = stat_reg[S_TMR0];
  assign secondary_timer_irq_flag = stat_reg[S_TMR1];
  assign capture_irq_flag         = stat_reg[S_CAP];
  assign capture_wake_flag        = stat_reg[S_WAKE];
  assign compare_irq_flag         = stat_reg[S_CMP];
  assign compare_irq_req          = irq_req_reg;

endmodule

/* File: dv/tpc_top_chk.sv */
/*
  Checker for tpc_top: APB answer timing and compare pulse relations.
  Assumes it is bound into tpc_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module tpc_top_chk (
  input wire logic                       pclk,     // Clock
  input wire logic                       presetn,  // Reset, low
  input wire logic                       ce,       // Clock enable
  input wire logic                       psel,     // APB select
  input wire logic                       penable,  // APB enable
  input wire logic                       pwrite,   // APB write
  input wire logic [tpc_pkg::APB_AW-1:0] paddr,    // APB address
  input wire logic [31:0]                pwdata,   // APB wdata
  input wire logic [31:0]                prdata,   // APB rdata
  input wire logic                       pready,   // APB ready
  input wire logic                       pslverr,  // APB error
  input wire logic                       compare_out_pin,  // Pulse
  input wire logic                       primary_timer_irq_flag, // Flag
  input wire logic                       compare_irq_flag, // Flag
  input wire logic                       compare_irq_req   // Masked
);
  import tpc_pkg::*;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completed write; the pulse may also fall when software rewrites mode
  wire wr_done = psel && penable && pready && pwrite;

  sequence s_pulse_end;
    compare_out_pin ##1 !compare_out_pin;
  endsequence

  sequence s_arm_write;
    wr_done && paddr == OFS_CMPCTL && pwdata[2:0] == CMP_SINGLE;
  endsequence

  chk_ready_after: assert property (
    psel && penable && !pready && ce |=> pready)
    else $error("pready missing after access cycle");
  chk_ready_single: assert property (pready && ce |=> !pready)
    else $error("pready held too long");
  chk_slverr_map: assert property (pready && paddr > OFS_STATUS |-> pslverr)
    else $error("unmapped access without error");
  chk_rdata_upper: assert property (
    pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_req_lag: assert property (
    compare_irq_req |-> $past(compare_irq_flag))
    else $error("compare request without flag");
  chk_flag_sticky: assert property (
    $fell(primary_timer_irq_flag) |->
    $past(wr_done && paddr == OFS_STATUS && pwdata[S_TMR0]))
    else $error("period flag dropped without clear");
  chk_pulse_end: assert property (s_pulse_end |-> compare_irq_flag ||
    $past(wr_done) || $past(wr_done, 2))
    else $error("pulse fell without compare flag");
  chk_arm_low: assert property (
    s_arm_write |-> ##[1:2] !compare_out_pin)
    else $error("pin not low after arming");
endmodule

bind tpc_top tpc_top_chk u_chk (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .compare_out_pin,
  .primary_timer_irq_flag, .compare_irq_flag, .compare_irq_req);

/* File: dv/timer_pair_capture_compare_tb.sv */
/*
  Self-checking bench for tpc_top: registers, timers, capture, compare.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ns
module timer_pair_capture_compare_tb;
  import tpc_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, q;
  logic              pslverr, idle_mode, sleep_mode, capture_pin, cpo;
  logic [1:0]        ext_pin, gate_pin;
  logic              f0, f1, fcmp, req, fcap, fwk;
  int                failures, cmp_count, n;

  tpc_top dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .idle_mode,
    .sleep_mode, .ext_timer_clock_pin(ext_pin), .gate_pin,
    .capture_pin, .compare_out_pin(cpo), .primary_timer_irq_flag(f0),
    .secondary_timer_irq_flag(f1), .capture_irq_flag(fcap),
    .capture_wake_flag(fwk), .compare_irq_flag(fcmp),
    .compare_irq_req(req));

  // Free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task tally_and_finish;
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  // One APB transfer; the wait is bounded so a stuck slave ends the run
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk("apb_ready", 32'h1, 32'h0);
      tally_and_finish;
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, e}, q);
  endtask

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // Count must (e=0) or must not (e=1) move over twenty cycles
  task frozen(input logic e);
    logic [31:0] v;
    apb(1'b0, OFS_CNT0, 16'h0000);
    v = q;
    cyc(20);
    apb(1'b0, OFS_CNT0, 16'h0000);
    chk("cnt_frozen", {31'h0, e}, {31'h0, q === v});
  endtask

  task wait_pin(input logic v);
    n = 0;
    while (cpo !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) begin
      chk("pin_wait", {31'h0, v}, {31'h0, cpo});
      tally_and_finish;
    end
  endtask

  task cpulse(input int k);
    repeat (k) begin
      capture_pin <= 1'b1;
      cyc(6);
      capture_pin <= 1'b0;
      cyc(6);
    end
  endtask

  task t_regs;
    rdchk("tctl0_rst", OFS_TCTL0, REG_RESET);
    rdchk("capctl_rst", OFS_CAPCTL, REG_RESET);
    apb(1'b1, OFS_TCTL0, 16'hFFFF);
    rdchk("tctl0_mask", OFS_TCTL0, TCTL0_MASK);
    apb(1'b1, OFS_TCTL1, 16'hFFFF);
    rdchk("tctl1_mask", OFS_TCTL1, TCTL1_MASK);
    apb(1'b1, OFS_CAPCTL, 16'hFFFF);
    rdchk("capctl_mask", OFS_CAPCTL, CAPCTL_MASK);
    apb(1'b1, OFS_TCTL0, 16'h0000);
    apb(1'b1, OFS_TCTL1, 16'h0000);
    apb(1'b1, OFS_CAPCTL, 16'h0000);
    apb(1'b0, 8'h30, 16'h0000);
    chk("unmapped_err", 32'h1, {31'h0, pslverr});
    chk("unmapped_rd", 32'h0, q);
  endtask

  task t_prescale;
    int d;
    for (int c = 0; c < 4; c++) begin
      d = (c == 3) ? 256 : (1 << (3 * c));
      apb(1'b1, OFS_PER0, 16'hFFFF);
      apb(1'b1, OFS_CNT0, 16'h0000);
      apb(1'b1, OFS_TCTL0, 16'h8000 | 16'(c << 4));
      cyc(2048);
      apb(1'b1, OFS_TCTL0, 16'h0000);
      apb(1'b0, OFS_CNT0, 16'h0000);
      chk("prescale", 32'h1,
          {31'h0, q >= 2048 / d && q <= 2064 / d + 1});
    end
  endtask

  task t_gate;
    apb(1'b1, OFS_TCTL0, 16'hA040);
    frozen(1'b0);
    idle_mode <= 1'b1;
    frozen(1'b1);
    apb(1'b1, OFS_TCTL0, 16'h8040);
    frozen(1'b0);
    idle_mode <= 1'b0;
    gate_pin  <= 2'b00;
    frozen(1'b1);
    apb(1'b1, OFS_TCTL0, 16'h0000);
    frozen(1'b1);
    apb(1'b1, OFS_CNT0, 16'h0000);
    apb(1'b1, OFS_TCTL0, 16'h8042);
    repeat (10) begin
      ext_pin[0] <= 1'b1;
      cyc(5);
      ext_pin[0] <= 1'b0;
      cyc(5);
    end
    cyc(10);
    rdchk("ext_count", OFS_CNT0, 16'h000A);
    apb(1'b1, OFS_TCTL0, 16'h0000);
    gate_pin <= 2'b11;
  endtask

  task t_chain;
    apb(1'b1, OFS_TCTL1, 16'h2000);
    idle_mode <= 1'b1;
    apb(1'b1, OFS_PER1, 16'h0001);
    apb(1'b1, OFS_CNT0, 16'hFFF0);
    apb(1'b1, OFS_CNT1, 16'h0000);
    apb(1'b1, OFS_STATUS, 16'hFFFF);
    apb(1'b1, OFS_TCTL0, 16'h8008);
    cyc(40);
    rdchk("chain_msw", OFS_CNT1, 16'h0001);
    apb(1'b1, OFS_TCTL0, 16'h0000);
    apb(1'b1, OFS_CNT0, 16'hFFF0);
    apb(1'b1, OFS_TCTL0, 16'h8008);
    cyc(40);
    rdchk("chain_wrap", OFS_CNT1, 16'h0000);
    chk("chain_flag1", 32'h1, {31'h0, f1});
    chk("chain_flag0", 32'h0, {31'h0, f0});
    idle_mode <= 1'b0;
    apb(1'b1, OFS_TCTL0, 16'h0000);
    apb(1'b1, OFS_TCTL1, 16'h0000);
  endtask

  task cap_case(input logic [15:0] w, input int k, input logic id,
                input logic bne, input logic [1:0] st);
    apb(1'b1, OFS_CAPCTL, 16'h0000);
    apb(1'b1, OFS_STATUS, 16'h001C);
    idle_mode <= id;
    apb(1'b1, OFS_CAPCTL, w);
    cpulse(k);
    idle_mode <= 1'b0;
    apb(1'b0, OFS_CAPCTL, 16'h0000);
    chk("cap_bne", {31'h0, bne}, {31'h0, q[C_BNE]});
    apb(1'b0, OFS_STATUS, 16'h0000);
    chk("cap_status", {30'h0, st}, {30'h0, q[3:2]});
    chk("cap_pins", {30'h0, st}, {30'h0, fwk, fcap});
  endtask

  task t_capture;
    apb(1'b1, OFS_CNT0, 16'h1234);
    apb(1'b1, OFS_CNT1, 16'h00AB);
    cap_case(16'h0083, 5, 1'b0, 1'b1, 2'b01);
    rdchk("cap_ovf", OFS_CAPCTL, 16'h009B);
    repeat (4) rdchk("cap_buf", OFS_CAPBUF, 16'h1234);
    rdchk("cap_empty", OFS_CAPCTL, 16'h0093);
    cap_case(16'h0002, 1, 1'b0, 1'b1, 2'b01);
    rdchk("cap_sec", OFS_CAPBUF, 16'h00AB);
    cap_case(16'h0006, 1, 1'b0, 1'b0, 2'b00);
    cap_case(16'h0000, 1, 1'b0, 1'b0, 2'b00);
    cap_case(16'h2083, 1, 1'b1, 1'b0, 2'b00);
    cap_case(16'h0084, 3, 1'b0, 1'b0, 2'b00);
    cap_case(16'h0084, 4, 1'b0, 1'b1, 2'b01);
    cap_case(16'h0085, 16, 1'b0, 1'b1, 2'b01);
    cap_case(16'h0023, 1, 1'b0, 1'b1, 2'b00);
    cap_case(16'h0023, 2, 1'b0, 1'b1, 2'b01);
    cap_case(16'h0061, 1, 1'b0, 1'b1, 2'b01);
    cap_case(16'h0007, 1, 1'b0, 1'b0, 2'b00);
    cap_case(16'h0007, 1, 1'b1, 1'b0, 2'b10);
    sleep_mode <= 1'b1;
    cap_case(16'h0007, 1, 1'b0, 1'b0, 2'b10);
    sleep_mode <= 1'b0;
  endtask

  task t_compare;
    apb(1'b1, OFS_CNT0, 16'h0000);
    apb(1'b1, OFS_PER0, 16'h0020);
    apb(1'b1, OFS_CMPVAL0, 16'h0005);
    apb(1'b1, OFS_CMPVAL1, 16'h0009);
    apb(1'b1, OFS_STATUS, 16'hFFFF);
    apb(1'b1, OFS_CMPCTL, 16'h0014);
    cyc(2);
    chk("cmp_armed", 32'h0, {31'h0, cpo});
    apb(1'b1, OFS_TCTL0, 16'h8000);
    wait_pin(1'b1);
    wait_pin(1'b0);
    cyc(2);
    chk("cmp_flag", 32'h1, {31'h0, fcmp});
    chk("cmp_req", 32'h1, {31'h0, req});
    n = 0;
    repeat (80) begin
      @(posedge pclk);
      if (cpo !== 1'b0) n++;
    end
    chk("cmp_low", 32'h0, n);
    apb(1'b1, OFS_STATUS, 16'h0010);
    apb(1'b1, OFS_CMPCTL, 16'h0004);
    wait_pin(1'b1);
    wait_pin(1'b0);
    cyc(2);
    chk("rearm_flag", 32'h1, {31'h0, fcmp});
    chk("rearm_req", 32'h0, {31'h0, req});
    chk("period_flag", 32'h1, {31'h0, f0});
    apb(1'b1, OFS_TCTL0, 16'h0000);
    apb(1'b1, OFS_STATUS, 16'h0001);
    cyc(1);
    chk("period_clr", 32'h0, {31'h0, f0});
  endtask

  // Reset for two cycles, then run every scenario in turn
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    idle_mode   = 1'b0;
    sleep_mode  = 1'b0;
    capture_pin = 1'b0;
    ext_pin     = 2'b00;
    gate_pin    = 2'b11;
    failures    = 0;
    cmp_count   = 0;
    cyc(2);
    presetn <= 1'b1;
    t_regs;
    t_prescale;
    t_gate;
    t_chain;
    t_capture;
    t_compare;
    tally_and_finish;
  end
endmodule
